// file: core/ieb_top.v
/*
 Interrupt enable bank: four enable registers, matching flag registers,
 gated request outputs per source, pending vectors for the core and a
 summary interrupt with sticky status, clear and enable registers.
 Writes land at the edge that ends the single bus wait state.
 Assumes all sources and the bus master run on clk.
*/
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`include "ieb_consts.vh"
module ieb_top (
  input  wire                clk,
  input  wire                resetn,
  input  wire [`IEB_AW-1:0]  address,
  input  wire                read,
  input  wire                write,
  input  wire [31:0]         writedata,
  input  wire [3:0]          byteenable,
  output wire                waitrequest,
  output wire [31:0]         readdata,
  output wire                irq,
  input  wire                req_timer_one,
  input  wire                req_compare_one,
  input  wire                req_capture_one,
  input  wire                req_ext_input_zero,
  input  wire                req_serial_two_tx,
  input  wire                req_serial_two_rx,
  input  wire                req_ext_input_two,
  input  wire                req_timer_five,
  input  wire                req_timer_four,
  input  wire                req_compare_four,
  input  wire                req_compare_three,
  input  wire                req_capture_eight,
  input  wire                req_capture_seven,
  input  wire                req_ext_input_one,
  input  wire                req_change_notify,
  input  wire                req_comparator,
  input  wire                req_i2c_one_master,
  input  wire                req_i2c_one_slave,
  input  wire                req_parallel_port,
  input  wire                req_compare_eight,
  input  wire                req_compare_seven,
  input  wire                req_compare_six,
  input  wire                req_compare_five,
  input  wire                req_capture_six,
  input  wire                req_capture_five,
  input  wire                req_capture_four,
  input  wire                req_capture_three,
  input  wire                req_spi_two_event,
  input  wire                req_spi_two_fault,
  input  wire                req_calendar,
  input  wire                req_ext_input_four,
  input  wire                req_ext_input_three,
  input  wire                req_i2c_two_master,
  input  wire                req_i2c_two_slave,
  output wire [15:0]         gated_0,
  output wire [15:0]         gated_1,
  output wire [15:0]         gated_2,
  output wire [15:0]         gated_3,
  output wire [15:0]         pend_0,
  output wire [15:0]         pend_1,
  output wire [15:0]         pend_2,
  output wire [15:0]         pend_3
);
  wire [15:0] src_0;
  wire [15:0] src_1;
  wire [15:0] src_2;
  wire [15:0] src_3;
  wire [15:0] en_0;
  wire [15:0] en_1;
  wire [15:0] en_2;
  wire [15:0] en_3;
  wire [15:0] fl_0;
  wire [15:0] fl_1;
  wire [15:0] fl_2;
  wire [15:0] fl_3;
  wire        wr_fire;
  wire [15:0] lane_mask;
  wire [15:0] wdata;
  reg  [15:0] reg_rdata;
  reg  [15:0] pend_d_0;
  reg  [15:0] pend_d_1;
  reg  [15:0] pend_d_2;
  reg  [15:0] pend_d_3;
  reg  [3:0]  stat;
  reg  [3:0]  ien;
  wire [3:0]  new_pend;
  wire [3:0]  clr_bits;
  wire [3:0]  next_stat;
  wire        sel_en_0;
  wire        sel_en_1;
  wire        sel_en_2;
  wire        sel_en_3;
  wire        sel_fl_0;
  wire        sel_fl_1;
  wire        sel_fl_2;
  wire        sel_fl_3;
  wire        sel_clr;
  wire        sel_ien;
  wire        en_we_0;
  wire        en_we_1;
  wire        en_we_2;
  wire        en_we_3;
  wire        fl_we_0;
  wire        fl_we_1;
  wire        fl_we_2;
  wire        fl_we_3;
  wire        clr_we;
  wire        ien_we;

  assign wdata = writedata[15:0];

  // Exact offsets only, so misaligned accesses hit nothing
  assign sel_en_0 = (address == `IEB_OFS_EN0);
  assign sel_en_1 = (address == `IEB_OFS_EN1);
  assign sel_en_2 = (address == `IEB_OFS_EN2);
  assign sel_en_3 = (address == `IEB_OFS_EN3);
  assign sel_fl_0 = (address == `IEB_OFS_FLG0);
  assign sel_fl_1 = (address == `IEB_OFS_FLG1);
  assign sel_fl_2 = (address == `IEB_OFS_FLG2);
  assign sel_fl_3 = (address == `IEB_OFS_FLG3);
  assign sel_clr  = (address == `IEB_OFS_CLR);
  assign sel_ien  = (address == `IEB_OFS_IEN);

  // Strobes fire once, at the edge that ends the wait state
  assign en_we_0 = wr_fire & sel_en_0;
  assign en_we_1 = wr_fire & sel_en_1;
  assign en_we_2 = wr_fire & sel_en_2;
  assign en_we_3 = wr_fire & sel_en_3;
  assign fl_we_0 = wr_fire & sel_fl_0;
  assign fl_we_1 = wr_fire & sel_fl_1;
  assign fl_we_2 = wr_fire & sel_fl_2;
  assign fl_we_3 = wr_fire & sel_fl_3;
  assign clr_we  = wr_fire & byteenable[0] & sel_clr;
  assign ien_we  = wr_fire & byteenable[0] & sel_ien;

  // Source layout per register, unimplemented slots tied low
  assign src_0 = {`IEB_PAD12,
                  req_timer_one,
                  req_compare_one,
                  req_capture_one,
                  req_ext_input_zero};
  assign src_1 = {req_serial_two_tx,
                  req_serial_two_rx,
                  req_ext_input_two,
                  req_timer_five,
                  req_timer_four,
                  req_compare_four,
                  req_compare_three,
                  `IEB_PAD1,
                  req_capture_eight,
                  req_capture_seven,
                  `IEB_PAD1,
                  req_ext_input_one,
                  req_change_notify,
                  req_comparator,
                  req_i2c_one_master,
                  req_i2c_one_slave};
  assign src_2 = {`IEB_PAD2,
                  req_parallel_port,
                  req_compare_eight,
                  req_compare_seven,
                  req_compare_six,
                  req_compare_five,
                  req_capture_six,
                  req_capture_five,
                  req_capture_four,
                  req_capture_three,
                  `IEB_PAD3,
                  req_spi_two_event,
                  req_spi_two_fault};
  assign src_3 = {`IEB_PAD1,
                  req_calendar,
                  `IEB_PAD7,
                  req_ext_input_four,
                  req_ext_input_three,
                  `IEB_PAD2,
                  req_i2c_two_master,
                  req_i2c_two_slave,
                  `IEB_PAD1};

  ieb_avalon_slave u_bus (
    .clk         (clk),
    .resetn      (resetn),
    .read        (read),
    .write       (write),
    .byteenable  (byteenable),
    .reg_rdata   (reg_rdata),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .wr_fire     (wr_fire),
    .lane_mask   (lane_mask)
  );

  // Unimplemented positions get no flops at all
  ieb_gate_bank #(.IMPL(`IEB_MASK_EN0)) u_bank0 (
    .clk     (clk),
    .resetn  (resetn),
    .en_we   (en_we_0),
    .flag_we (fl_we_0),
    .wdata   (wdata),
    .wmask   (lane_mask),
    .src     (src_0),
    .enable  (en_0),
    .flag    (fl_0),
    .gated   (gated_0),
    .pend    (pend_0)
  );

  ieb_gate_bank #(.IMPL(`IEB_MASK_EN1)) u_bank1 (
    .clk     (clk),
    .resetn  (resetn),
    .en_we   (en_we_1),
    .flag_we (fl_we_1),
    .wdata   (wdata),
    .wmask   (lane_mask),
    .src     (src_1),
    .enable  (en_1),
    .flag    (fl_1),
    .gated   (gated_1),
    .pend    (pend_1)
  );

  ieb_gate_bank #(.IMPL(`IEB_MASK_EN2)) u_bank2 (
    .clk     (clk),
    .resetn  (resetn),
    .en_we   (en_we_2),
    .flag_we (fl_we_2),
    .wdata   (wdata),
    .wmask   (lane_mask),
    .src     (src_2),
    .enable  (en_2),
    .flag    (fl_2),
    .gated   (gated_2),
    .pend    (pend_2)
  );

  ieb_gate_bank #(.IMPL(`IEB_MASK_EN3)) u_bank3 (
    .clk     (clk),
    .resetn  (resetn),
    .en_we   (en_we_3),
    .flag_we (fl_we_3),
    .wdata   (wdata),
    .wmask   (lane_mask),
    .src     (src_3),
    .enable  (en_3),
    .flag    (fl_3),
    .gated   (gated_3),
    .pend    (pend_3)
  );

  // Register read mux; unmapped and write-only offsets read zero
  always @* begin
    case (address)
      `IEB_OFS_EN0:  reg_rdata = en_0;
      `IEB_OFS_EN1:  reg_rdata = en_1;
      `IEB_OFS_EN2:  reg_rdata = en_2;
      `IEB_OFS_EN3:  reg_rdata = en_3;
      `IEB_OFS_FLG0: reg_rdata = fl_0;
      `IEB_OFS_FLG1: reg_rdata = fl_1;
      `IEB_OFS_FLG2: reg_rdata = fl_2;
      `IEB_OFS_FLG3: reg_rdata = fl_3;
      `IEB_OFS_STAT: reg_rdata = {`IEB_PAD12, stat};
      `IEB_OFS_IEN:  reg_rdata = {`IEB_PAD12, ien};
      default:       reg_rdata = `IEB_RST16;
    endcase
  end

  // A bank raises its event when any source newly becomes pending
  assign new_pend[`IEB_ST_BANK0] = |(pend_0 & ~pend_d_0);
  assign new_pend[`IEB_ST_BANK1] = |(pend_1 & ~pend_d_1);
  assign new_pend[`IEB_ST_BANK2] = |(pend_2 & ~pend_d_2);
  assign new_pend[`IEB_ST_BANK3] = |(pend_3 & ~pend_d_3);

  assign clr_bits  = clr_we ? writedata[3:0] : `IEB_RST4;
  // New events win over a clear landing in the same cycle
  assign next_stat = (stat & ~clr_bits) | new_pend;

  // Previous pending vectors, for the rising-edge event
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_d_0 <= `IEB_RST16;
      pend_d_1 <= `IEB_RST16;
      pend_d_2 <= `IEB_RST16;
      pend_d_3 <= `IEB_RST16;
    end else begin
      pend_d_0 <= pend_0;
      pend_d_1 <= pend_1;
      pend_d_2 <= pend_2;
      pend_d_3 <= pend_3;
    end
  end

  // Sticky status and its interrupt enable
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat <= `IEB_RST4;
      ien  <= `IEB_RST4;
    end else begin
      stat <= next_stat;
      if (ien_we) begin
        ien <= writedata[3:0];
      end
    end
  end

  // Level output: stays high until status is cleared or masked
  assign irq = |(stat & ien);
endmodule

// file: inc/ieb_consts.vh
/*
 Constants for the interrupt enable bank: register offsets, implemented-bit
 masks, reset values and the status bit position of every bank.
 Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
`ifndef IEB_CONSTS_VH
`define IEB_CONSTS_VH

`define IEB_AW        8
`define IEB_OFS_EN0   8'h00
`define IEB_OFS_EN1   8'h04
`define IEB_OFS_EN2   8'h08
`define IEB_OFS_EN3   8'h0C
`define IEB_OFS_FLG0  8'h10
`define IEB_OFS_FLG1  8'h14
`define IEB_OFS_FLG2  8'h18
`define IEB_OFS_FLG3  8'h1C
`define IEB_OFS_STAT  8'h30
`define IEB_OFS_CLR   8'h34
`define IEB_OFS_IEN   8'h38

`define IEB_MASK_EN0  16'h000F
`define IEB_MASK_EN1  16'hFEDF
`define IEB_MASK_EN2  16'h3FE3
`define IEB_MASK_EN3  16'h4066

`define IEB_RST16     16'h0000
`define IEB_RST4      4'h0
`define IEB_PAD16     16'h0000
`define IEB_PAD12     12'h000
`define IEB_PAD7      7'h00
`define IEB_PAD3      3'h0
`define IEB_PAD2      2'h0
`define IEB_PAD1      1'b0

`define IEB_ST_BANK0  0
`define IEB_ST_BANK1  1
`define IEB_ST_BANK2  2
`define IEB_ST_BANK3  3

`endif

// file: core/ieb_avalon_slave.v
/*
 Avalon-MM slave front end: one wait state on every access, registered
 read data, write strobe at the edge that ends the wait.
 Assumes the master holds its request until waitrequest is seen low.
*/
`include "ieb_consts.vh"
module ieb_avalon_slave (
  input  wire        clk,
  input  wire        resetn,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [15:0] reg_rdata,
  output wire        waitrequest,
  output reg  [31:0] readdata,
  output wire        wr_fire,
  output wire [15:0] lane_mask
);
  reg ack;

  // One wait state gives the read mux a full cycle
  assign waitrequest = (read | write) & ~ack;
  assign wr_fire     = write & ack;
  assign lane_mask   = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack      <= 1'b0;
      readdata <= {`IEB_PAD16, `IEB_RST16};
    end else begin
      ack <= (read | write) & ~ack;
      if (read & ~ack) begin
        readdata <= {`IEB_PAD16, reg_rdata};
      end
    end
  end
endmodule

// file: core/ieb_gate_bank.v
/*
 One 16-bit bank of enable and flag bits with request gating.
 Assumes requests arrive from logic on the same clock.
*/
`include "ieb_consts.vh"
module ieb_gate_bank #(
  parameter [15:0] IMPL = 16'h0000
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        en_we,
  input  wire        flag_we,
  input  wire [15:0] wdata,
  input  wire [15:0] wmask,
  input  wire [15:0] src,
  output wire [15:0] enable,
  output wire [15:0] flag,
  output wire [15:0] gated,
  output wire [15:0] pend
);
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      if (IMPL[i]) begin : g_impl
        reg en_q;
        reg fl_q;
        reg pd_q;
        always @(posedge clk or negedge resetn) begin
          if (!resetn) begin
            en_q <= 1'b0;
            fl_q <= 1'b0;
            pd_q <= 1'b0;
          end else begin
            if (en_we & wmask[i]) begin
              en_q <= wdata[i];
            end
            // Hardware set beats a software clear in the same cycle
            fl_q <= ((flag_we & wmask[i]) ? wdata[i] : fl_q) | src[i];
            pd_q <= fl_q & en_q;
          end
        end
        assign enable[i] = en_q;
        assign flag[i]   = fl_q;
        assign gated[i]  = src[i] & en_q;
        assign pend[i]   = pd_q;
      end else begin : g_none
        assign enable[i] = 1'b0;
        assign flag[i]   = 1'b0;
        assign gated[i]  = 1'b0;
        assign pend[i]   = 1'b0;
      end
    end
  endgenerate
endmodule

// file: bench/ieb_checker.sv
/*
 Checker for the enable bank: bus wait states, masking of unused bits,
 reset state and request gating.
 Assumes it is bound to ieb_top and sees only that module's ports.
*/
module ieb_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic [31:0] readdata,
  input wire logic        irq,
  input wire logic        req_timer_one,
  input wire logic        req_calendar,
  input wire logic [15:0] gated_0,
  input wire logic [15:0] gated_1,
  input wire logic [15:0] gated_2,
  input wire logic [15:0] gated_3,
  input wire logic [15:0] pend_0,
  input wire logic [15:0] pend_1,
  input wire logic [15:0] pend_2,
  input wire logic [15:0] pend_3
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  wait_state_a: assert property ((read || write) && !waitrequest |=> waitrequest || !(read || write))
    else $error("access finished without a wait state");
  wait_bound_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access held more than one wait state");
  idle_wait_a: assert property (!(read || write) |-> !waitrequest)
    else $error("wait state without a request");
  gate_mask_a: assert property (((gated_0 & 16'hFFF0) | (gated_1 & 16'h0120)
    | (gated_2 & 16'hC01C) | (gated_3 & 16'hBF99)) == 16'h0000)
    else $error("request passed at an unused bit");
  pend_mask_a: assert property (((pend_0 & 16'hFFF0) | (pend_1 & 16'h0120)
    | (pend_2 & 16'hC01C) | (pend_3 & 16'hBF99)) == 16'h0000)
    else $error("pending shown at an unused bit");
  reset_clear_a: assert property (!$past(resetn) |-> !irq && readdata == 32'h0
    && (gated_0 | gated_1 | gated_2 | gated_3 | pend_0 | pend_1 | pend_2 | pend_3) == 16'h0000)
    else $error("state not clear after reset");
  timer_gate_a: assert property (!req_timer_one |-> !gated_0[3])
    else $error("timer gate passed without request");
  cal_gate_a: assert property (!req_calendar |-> !gated_3[14])
    else $error("calendar gate passed without request");
  // Enable must still stand one cycle on, or software may have withdrawn it
  pend_follow_a: assert property ((gated_1 != 16'h0000) ##1 ((gated_1 & $past(gated_1)) == $past(gated_1))
    |=> (pend_1 & $past(gated_1, 2)) == $past(gated_1, 2))
    else $error("passed request not pending two cycles later");

  cover property (read && !waitrequest);
  cover property ($rose(irq));
  cover property (pend_2 != 16'h0000);
endmodule

bind ieb_top ieb_checker chk (.clk(clk), .resetn(resetn), .read(read), .write(write), .waitrequest(waitrequest),
  .readdata(readdata), .irq(irq), .req_timer_one(req_timer_one), .req_calendar(req_calendar),
  .gated_0(gated_0), .gated_1(gated_1), .gated_2(gated_2), .gated_3(gated_3),
  .pend_0(pend_0), .pend_1(pend_1), .pend_2(pend_2), .pend_3(pend_3));

// file: bench/ieb_src_model.sv
/*
 Model of the peripheral request sources feeding the bank.
 Assumes the bench commands a level pattern, one bit per source position.
*/
module ieb_src_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [63:0] cmd,
  output logic      [63:0] rq
);
  timeunit 1ns;
  timeprecision 1ns;
  // External inputs taken as already routed to a remap pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      rq <= 64'h0;
    else
      rq <= cmd;
  end
endmodule

// file: bench/interrupt_enable_bank_tb.sv
/*
 Self-checking bench for the interrupt enable bank.
 Assumes ieb_top, its checker and the source model are compiled before it.
*/
module interrupt_enable_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] impl_mask = 64'h4066_3FE3_FEDF_000F;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h0;
  logic [63:0] cmd = 64'h0;
  wire         waitrequest;
  wire         irq;
  wire  [31:0] readdata;
  wire  [63:0] rq;
  wire  [63:0] gv;
  wire  [63:0] pv;
  int          fails = 0;
  int          checks_done = 0;

  always #25 clk = ~clk;

  ieb_src_model src (.clk(clk), .resetn(resetn), .cmd(cmd), .rq(rq));

  ieb_top dut (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest), .readdata(readdata), .irq(irq),
    .req_timer_one(rq[3]), .req_compare_one(rq[2]), .req_capture_one(rq[1]), .req_ext_input_zero(rq[0]),
    .req_serial_two_tx(rq[31]), .req_serial_two_rx(rq[30]), .req_ext_input_two(rq[29]), .req_timer_five(rq[28]),
    .req_timer_four(rq[27]), .req_compare_four(rq[26]), .req_compare_three(rq[25]), .req_capture_eight(rq[23]),
    .req_capture_seven(rq[22]), .req_ext_input_one(rq[20]), .req_change_notify(rq[19]), .req_comparator(rq[18]),
    .req_i2c_one_master(rq[17]), .req_i2c_one_slave(rq[16]), .req_parallel_port(rq[45]),
    .req_compare_eight(rq[44]), .req_compare_seven(rq[43]), .req_compare_six(rq[42]), .req_compare_five(rq[41]),
    .req_capture_six(rq[40]), .req_capture_five(rq[39]), .req_capture_four(rq[38]), .req_capture_three(rq[37]),
    .req_spi_two_event(rq[33]), .req_spi_two_fault(rq[32]), .req_calendar(rq[62]), .req_ext_input_four(rq[54]),
    .req_ext_input_three(rq[53]), .req_i2c_two_master(rq[50]), .req_i2c_two_slave(rq[49]),
    .gated_0(gv[15:0]), .gated_1(gv[31:16]), .gated_2(gv[47:32]), .gated_3(gv[63:48]),
    .pend_0(pv[15:0]), .pend_1(pv[31:16]), .pend_2(pv[47:32]), .pend_3(pv[63:48]));

  task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge; no latency assumed
  task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    read <= !we;
    write <= we;
    address <= a;
    writedata <= {16'h0000, d};
    byteenable <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      summarize();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    check(nm, {32'h0, q}, {32'h0, exp});
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++)
      rd_chk("enable after reset", 8'(4 * i), 32'h0);
    rd_chk("unmapped read", 8'h20, 32'h0);
  endtask

  task automatic t_rw();
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i), 16'hFFFF);
      rd_chk("enable ones", 8'(4 * i), {16'h0, impl_mask[16 * i +: 16]});
      wr(8'(4 * i), 16'h5A5A);
      rd_chk("enable pattern", 8'(4 * i), {16'h0, impl_mask[16 * i +: 16] & 16'h5A5A});
    end
  endtask

  task automatic t_gate();
    for (int i = 0; i < 4; i++)
      wr(8'(4 * i), 16'h0000);
    @(posedge clk);
    cmd <= {64{1'b1}};
    repeat (3) @(negedge clk);
    check("gated while disabled", gv, 64'h0);
    for (int i = 0; i < 4; i++)
      wr(8'(4 * i), 16'hFFFF);
    @(negedge clk);
    check("gated map", gv, impl_mask);
    repeat (2) @(negedge clk);
    check("pending", pv, impl_mask);
    // One source at a time, so a swapped position shows up
    for (int b = 0; b < 64; b++) begin
      @(posedge clk);
      cmd <= 64'h1 << b;
      repeat (2) @(negedge clk);
      check("gated walk", gv, impl_mask & (64'h1 << b));
    end
    for (int i = 0; i < 4; i++)
      rd_chk("flag set", 8'(16 + 4 * i), {16'h0, impl_mask[16 * i +: 16]});
    @(posedge clk);
    cmd <= 64'h0;
    for (int i = 0; i < 4; i++)
      wr(8'(16 + 4 * i), 16'h0000);
    repeat (2) @(negedge clk);
    check("pending after flag clear", pv, 64'h0);
    check("gated idle", gv, 64'h0);
  endtask

  // Status stays set from the pending rise in every bank
  task automatic t_irq();
    rd_chk("status sticky", 8'h30, 32'hF);
    check("irq masked", {63'h0, irq}, 64'h0);
    wr(8'h38, 16'h000F);
    @(negedge clk);
    check("irq raised", {63'h0, irq}, 64'h1);
    rd_chk("irq enable readback", 8'h38, 32'hF);
    wr(8'h38, 16'h0000);
    @(negedge clk);
    check("irq after mask", {63'h0, irq}, 64'h0);
    wr(8'h34, 16'h000F);
    rd_chk("status cleared", 8'h30, 32'h0);
    rd_chk("clear reads zero", 8'h34, 32'h0);
    wr(8'h38, 16'h000F);
    @(negedge clk);
    check("irq after clear", {63'h0, irq}, 64'h0);
  endtask

  // Reset in mid-run must clear enables that were set
  task automatic t_reset_mid();
    wr(8'h04, 16'hFFFF);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("enable after mid reset", 8'h04, 32'h0);
    rd_chk("irq enable after mid reset", 8'h38, 32'h0);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rw();
    t_gate();
    t_irq();
    t_reset_mid();
    summarize();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
